// *** adss_pkg.sv ***
// Shared constants and types for the A/D sweep sequencer
package adss_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFF_CTRL_THIRD  = 8'h08;
  localparam logic [7:0] OFF_STATUS      = 8'h0C;
  localparam logic [7:0] OFF_RESULT_BASE = 8'h20;
  localparam logic [7:0] OFF_RESULT_LAST = 8'h3C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB      = 0;   // converter_ctrl_first[1:0]
  localparam int TRIG_SEL_BIT  = 2;   // converter_ctrl_first[2]
  localparam int RUN_BIT       = 3;   // converter_ctrl_first[3]
  localparam int WIDTH_LSB     = 0;   // converter_ctrl_second[1:0]
  localparam int GROUP_LSB     = 1;   // converter_ctrl_third[2:1]
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_ARMED_BIT  = 1;
  localparam int ST_CHAN_LSB   = 4;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int NUM_CHAN  = 8;
  localparam int RESULT_W  = 10;
  localparam logic [2:0] LAST_CHAN = 3'h7;
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [1:0] WIDTH_RESET = 2'h0;
  localparam logic [1:0] GROUP_RESET = 2'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

  // Input group select codes and decoded group numbers
  localparam logic [1:0] GSEL_FIRST  = 2'h0;
  localparam logic [1:0] GSEL_SECOND = 2'h2;
  localparam logic [1:0] GSEL_THIRD  = 2'h3;
  localparam logic [1:0] GRP_FIRST   = 2'h0;
  localparam logic [1:0] GRP_SECOND  = 2'h1;
  localparam logic [1:0] GRP_THIRD   = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_REP0   = 2'h1,
    MODE_REP1   = 2'h2,
    MODE_RSVD   = 2'h3
  } adss_mode_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       trig_sel;
    logic       run;
    logic [1:0] width;
    logic [1:0] group_sel;
  } adss_ctrl_s;

  typedef struct packed {
    logic [1:0] group;
    logic [2:0] channel;
  } adss_conv_s;

endpackage

// *** adss_sweep_sequencer.sv ***
// A/D sweep sequencer with AHB-Lite register slave
`timescale 1ns/1ps

module adss_sweep_sequencer (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [7:0]                    haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  input  wire logic                          ext_trigger_in,
  output logic                               conv_start,
  output adss_pkg::adss_conv_s               conv_sel,
  input  wire logic                          conv_done,
  input  wire logic [adss_pkg::RESULT_W-1:0] conv_data,
  output logic                               conv_complete_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_START, ST_WAIT} adss_state_e;

  adss_state_e          state_r;
  adss_pkg::adss_ctrl_s ctrl_r;
  logic [adss_pkg::RESULT_W-1:0] result_r [adss_pkg::NUM_CHAN];
  logic [2:0]  chan_r;        // channel now being converted
  logic [2:0]  pri_r;         // next primary channel, repeat sweep 1
  logic [2:0]  oth_r;         // next other channel, repeat sweep 1
  logic        trig_prev_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  logic        irq_r;
  logic        start_r;

  logic        addr_ok;
  logic        wr_en;
  logic        wr_ctrl0;
  logic        run_wr_one;
  logic        run_wr_zero;
  logic        trig_fall;
  logic        seq_go;
  logic        conv_end;
  logic        last_pick;
  logic [2:0]  last_chan;
  logic [2:0]  last_pri;
  logic [2:0]  first_oth;
  logic [2:0]  next_chan;
  logic        sweep_done;
  logic [2:0]  next_pri;
  logic [2:0]  next_oth;
  logic [1:0]  grp_dec;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Address phase taken only for a selected NONSEQ/SEQ while bus ready
  assign addr_ok = hsel & htrans[1] & hready;

  // Reads insert one wait so a write just before is already visible
  assign hreadyout = ~rd_pend_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      if (addr_ok) begin
        addr_r <= haddr;
      end
      wr_pend_r <= addr_ok & hwrite;
      rd_pend_r <= addr_ok & ~hwrite;
    end
  end

  assign wr_en       = wr_pend_r;
  assign wr_ctrl0    = wr_en & (addr_r == adss_pkg::OFF_CTRL_FIRST);
  assign run_wr_one  = wr_ctrl0 & hwdata[adss_pkg::RUN_BIT];
  assign run_wr_zero = wr_ctrl0 & ~hwdata[adss_pkg::RUN_BIT];

  // Read multiplexer; unmapped words and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_r == adss_pkg::OFF_CTRL_FIRST) begin
      rd_mux[adss_pkg::MODE_LSB +: 2]  = ctrl_r.mode;
      rd_mux[adss_pkg::TRIG_SEL_BIT]   = ctrl_r.trig_sel;
      rd_mux[adss_pkg::RUN_BIT]        = ctrl_r.run;
    end else if (addr_r == adss_pkg::OFF_CTRL_SECOND) begin
      rd_mux[adss_pkg::WIDTH_LSB +: 2] = ctrl_r.width;
    end else if (addr_r == adss_pkg::OFF_CTRL_THIRD) begin
      rd_mux[adss_pkg::GROUP_LSB +: 2] = ctrl_r.group_sel;
    end else if (addr_r == adss_pkg::OFF_STATUS) begin
      rd_mux[adss_pkg::ST_BUSY_BIT]    = (state_r == ST_START) | (state_r == ST_WAIT);
      rd_mux[adss_pkg::ST_ARMED_BIT]   = (state_r == ST_ARMED);
      rd_mux[adss_pkg::ST_CHAN_LSB +: 3] = chan_r;
    end else if (addr_r >= adss_pkg::OFF_RESULT_BASE &&
                 addr_r <= adss_pkg::OFF_RESULT_LAST && addr_r[1:0] == 2'h0) begin
      // One result per aligned word, indexed by address bits 4:2
      rd_mux[adss_pkg::RESULT_W-1:0]   = result_r[addr_r[4:2]];
    end
  end

  // Read data registered during the wait cycle
  // Holding it in a flop keeps the result store off the bus path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Mode, trigger select, run bit and configuration fields
  // Run bit: a software write in the same cycle outranks the auto clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r.mode      <= adss_pkg::MODE_RESET;
      ctrl_r.trig_sel  <= 1'b0;
      ctrl_r.run       <= 1'b0;
      ctrl_r.width     <= adss_pkg::WIDTH_RESET;
      ctrl_r.group_sel <= adss_pkg::GROUP_RESET;
    end else begin
      if (wr_ctrl0) begin
        ctrl_r.mode     <= hwdata[adss_pkg::MODE_LSB +: 2];
        ctrl_r.trig_sel <= hwdata[adss_pkg::TRIG_SEL_BIT];
        ctrl_r.run      <= hwdata[adss_pkg::RUN_BIT];
      end else if (sweep_done && ctrl_r.mode != adss_pkg::MODE_REP0 &&
                   ctrl_r.mode != adss_pkg::MODE_REP1 && !ctrl_r.trig_sel) begin
        ctrl_r.run <= 1'b0;
      end
      if (wr_en && addr_r == adss_pkg::OFF_CTRL_SECOND) begin
        ctrl_r.width <= hwdata[adss_pkg::WIDTH_LSB +: 2];
      end
      if (wr_en && addr_r == adss_pkg::OFF_CTRL_THIRD) begin
        ctrl_r.group_sel <= hwdata[adss_pkg::GROUP_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger handling
  // ----------------------------------------------------------------
  // Previous pin level for falling edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev_r <= 1'b1;
    end else begin
      trig_prev_r <= ext_trigger_in;
    end
  end

  assign trig_fall = trig_prev_r & ~ext_trigger_in;

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  // width to last channel
  assign last_chan = {ctrl_r.width, 1'b1};
  assign last_pri  = {1'b0, ctrl_r.width};
  assign first_oth = last_pri + 3'h1;

  // group field decode; reserved code falls back to first group
  always_comb begin
    unique case (ctrl_r.group_sel)
      adss_pkg::GSEL_SECOND: grp_dec = adss_pkg::GRP_SECOND;
      adss_pkg::GSEL_THIRD:  grp_dec = adss_pkg::GRP_THIRD;
      default:               grp_dec = adss_pkg::GRP_FIRST;
    endcase
  end

  // channel and group to front end
  // One assignment keeps group and channel from ever disagreeing
  assign conv_sel = '{group: grp_dec, channel: chan_r};

  // Next channel after the current conversion
  assign conv_end = (state_r == ST_WAIT) & conv_done;

  always_comb begin
    next_chan  = chan_r + 3'h1;
    next_pri   = pri_r;
    next_oth   = oth_r;
    sweep_done = 1'b0;
    last_pick  = 1'b0;
    unique case (ctrl_r.mode)
      adss_pkg::MODE_REP0: begin
        if (chan_r == last_chan) begin
          next_chan = 3'h0;
        end
      end
      adss_pkg::MODE_REP1: begin
        if (chan_r <= last_pri && pri_r != 3'h0) begin
          next_chan = pri_r;
          next_pri  = (pri_r == last_pri) ? 3'h0 : pri_r + 3'h1;
        end else if (chan_r <= last_pri) begin
          next_chan = oth_r;
          last_pick = 1'b1;
          next_oth  = (oth_r == adss_pkg::LAST_CHAN) ? first_oth : oth_r + 3'h1;
        end else begin
          next_chan = 3'h0;
          next_pri  = (last_pri == 3'h0) ? 3'h0 : 3'h1;
        end
      end
      default: begin
        if (chan_r == last_chan) begin
          sweep_done = conv_end;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sweep state machine
  // ----------------------------------------------------------------
  // trigger start on a falling trigger edge while armed
  assign seq_go = (state_r == ST_ARMED) & trig_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      chan_r  <= 3'h0;
      pri_r   <= 3'h0;
      oth_r   <= 3'h0;
    end else if (run_wr_zero) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // start or arm on run write
          if (run_wr_one) begin
            chan_r  <= 3'h0;
            pri_r   <= (last_pri == 3'h0) ? 3'h0 : 3'h1;
            oth_r   <= first_oth;
            state_r <= hwdata[adss_pkg::TRIG_SEL_BIT] ? ST_ARMED : ST_START;
          end
        end
        ST_ARMED: begin
          if (seq_go) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_done) begin
            if (sweep_done) begin
              state_r <= ST_IDLE;
            end else begin
              chan_r  <= next_chan;
              pri_r   <= next_pri;
              oth_r   <= last_pick ? next_oth : oth_r;
              state_r <= ST_START;
            end
          end
        end
      endcase
    end
  end

  // One-cycle start pulse to the front end, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= (state_r == ST_START) & ~run_wr_zero;
    end
  end

  assign conv_start = start_r;

  // ----------------------------------------------------------------
  // Results and completion request
  // ----------------------------------------------------------------
  // per-channel result store; halted conversions are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < adss_pkg::NUM_CHAN; i++) begin
        result_r[i] <= adss_pkg::RESULT_RESET;
      end
    end else if (conv_end && !run_wr_zero) begin
      result_r[chan_r] <= conv_data;
    end
  end

  // completion pulse in single sweep and reserved mode code 3 only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= sweep_done & ~run_wr_zero;
    end
  end

  assign conv_complete_irq = irq_r;

endmodule

// *** adss_sweep_properties.sv ***
// Port assertions for the A/D sweep sequencer
`timescale 1ns/1ps
module adss_sweep_properties (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [7:0]           haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 ext_trigger_in,
  input wire logic                 conv_start,
  input wire adss_pkg::adss_conv_s conv_sel,
  input wire logic                 conv_done,
  input wire logic                 conv_complete_irq
);
  localparam int RB = adss_pkg::RUN_BIT;
  localparam int TB = adss_pkg::TRIG_SEL_BIT;
  logic wr0_q;
  logic live_q;
  logic armed_q;
  logic rep_q;
  wire  rd_req = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------
  // Helper state
  // ------------------------------------
  // Data phase of a write to the first control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr0_q <= 1'b0;
    else wr0_q <= hsel && htrans[1] && hready && hwrite && haddr == adss_pkg::OFF_CTRL_FIRST;
  end
  // Run, arm and mode as last written; a run write while live is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q  <= 1'b0;
      armed_q <= 1'b0;
      rep_q   <= 1'b0;
    end else if (wr0_q) begin
      live_q  <= hwdata[RB];
      armed_q <= hwdata[RB] && (live_q ? armed_q : hwdata[TB]);
      rep_q   <= ^hwdata[1:0];
    end else begin
      if (conv_complete_irq) live_q <= 1'b0;
      if (conv_start) armed_q <= 1'b0;
    end
  end
  // ------------------------------------
  // Properties
  // ------------------------------------
  // Request pulse spacing and channel hold
  property p_start_gap; conv_start |=> (!conv_start) [*2]; endproperty
  a_start_gap: assert property (p_start_gap) else $error("conv_start too close");
  property p_sel_hold; conv_start |=> $stable(conv_sel); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("conv_sel moved");
  // Start causes: software write, trigger edge only once armed
  property p_sw_start; wr0_q && hwdata[RB] && !hwdata[TB] && !live_q |-> ##2 conv_start;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missing");
  property p_hw_start; armed_q && $fell(ext_trigger_in) |-> ##[1:3] conv_start; endproperty
  a_hw_start: assert property (p_hw_start) else $error("trigger start missing");
  property p_hw_wait; armed_q && ext_trigger_in |=> !conv_start; endproperty
  a_hw_wait: assert property (p_hw_wait) else $error("start without trigger");
  // Halt and completion request
  property p_halt; wr0_q && !hwdata[RB] |-> ##2 (!conv_start) [*6]; endproperty
  a_halt: assert property (p_halt) else $error("start after halt");
  property p_irq_cause; conv_complete_irq |-> $past(conv_done) || $past(conv_done, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without conversion");
  property p_rep_no_irq; rep_q && live_q |-> !conv_complete_irq; endproperty
  a_rep_no_irq: assert property (p_rep_no_irq) else $error("irq in repeat mode");
  // Every register read takes one wait state
  property p_rd_wait; rd_req |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  c_irq: cover property (conv_complete_irq);
  c_rep: cover property (rep_q && conv_start);
  c_trig: cover property (armed_q && $fell(ext_trigger_in));
endmodule

bind adss_sweep_sequencer adss_sweep_properties u_props (
  .hclk              (hclk),
  .hresetn           (hresetn),
  .hsel              (hsel),
  .haddr             (haddr),
  .htrans            (htrans),
  .hwrite            (hwrite),
  .hwdata            (hwdata),
  .hready            (hready),
  .hreadyout         (hreadyout),
  .ext_trigger_in    (ext_trigger_in),
  .conv_start        (conv_start),
  .conv_sel          (conv_sel),
  .conv_done         (conv_done),
  .conv_complete_irq (conv_complete_irq)
);

// *** adss_fe_model.sv ***
// Behavioural analog front end answering conversion requests
`timescale 1ns/1ps
module adss_fe_model (
  input  wire logic                 hclk,
  input  wire logic                 conv_start,
  input  wire adss_pkg::adss_conv_s conv_sel,
  input  wire logic                 slow,
  output logic                      conv_done,
  output logic [9:0]                conv_data
);
  adss_pkg::adss_conv_s s;
  // ------------------------------------
  // Converter
  // ------------------------------------
  // result names its channel
  initial begin
    conv_done = 1'b0;
    conv_data = 10'h3FF;
    forever begin
      @(negedge hclk);
      if (conv_start === 1'b1) begin
        s = conv_sel;
        repeat (slow ? 4 : 1) @(posedge hclk);
        conv_done <= 1'b1;
        conv_data <= {3'h5, s, 2'h2};
        @(posedge hclk);
        conv_done <= 1'b0;
        // Stale data inverted so a late capture is caught
        conv_data <= ~{3'h5, s, 2'h2};
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the A/D sweep sequencer
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] C0 = adss_pkg::OFF_CTRL_FIRST;
  localparam logic [7:0] C1 = adss_pkg::OFF_CTRL_SECOND;
  localparam logic [7:0] C2 = adss_pkg::OFF_CTRL_THIRD;
  localparam logic [7:0] CS = adss_pkg::OFF_STATUS;
  logic                 hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic                 ext_trigger_in, conv_start, conv_done, conv_complete_irq, slow;
  logic [7:0]           haddr;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [31:0]          hwdata, hrdata, r;
  logic [9:0]           conv_data;
  adss_pkg::adss_conv_s conv_sel;
  logic [31:0]          q[$];
  logic [1:0]           gc[4] = '{2'h0, 2'h2, 2'h3, 2'h2};
  logic [1:0]           gd[4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  int                   fails, total_checks;
  assign hready = hreadyout;
  adss_sweep_sequencer DUT (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hready),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .hrdata            (hrdata),
    .ext_trigger_in    (ext_trigger_in),
    .conv_start        (conv_start),
    .conv_sel          (conv_sel),
    .conv_done         (conv_done),
    .conv_data         (conv_data),
    .conv_complete_irq (conv_complete_irq)
  );
  adss_fe_model u_fe (
    .hclk       (hclk),
    .conv_start (conv_start),
    .conv_sel   (conv_sel),
    .slow       (slow),
    .conv_done  (conv_done),
    .conv_data  (conv_data)
  );
  // Free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ------------------------------------
  // Tasks
  // ------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A spent bound ends the run
  task automatic tmo(input int n);
    if (n >= 3000) begin
      fails++;
      print_verdict();
    end
  endtask
  // Hold until hready is seen high at a falling edge, then step to the rising edge; data kept from that cycle
  task automatic hs;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      r = hrdata;
      n++;
    end while (hready !== 1'b1 && n < 3000);
    tmo(n);
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    hs();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hs();
  endtask
  // Wait for the irq, or for the queue to run down to a few spares
  task automatic wt(input bit irq);
    int n;
    n = 0;
    while ((irq ? conv_complete_irq !== 1'b1 : q.size() > 4) && n < 3000) begin
      @(negedge hclk);
      n++;
    end
    tmo(n);
    @(posedge hclk);
  endtask
  function automatic logic [31:0] dat(input logic [1:0] g, input logic [2:0] c);
    return {22'h0, 3'h5, g, c, 2'h2};
  endfunction
  // Repeat sweep: run, confirm run stays set, halt, confirm quiet
  task automatic rep(input logic [31:0] ctl);
    slow <= 1'($urandom);
    bus(1, C0, ctl);
    wt(0);
    bus(0, C0, 0);
    chk("run kept", ctl, r);
    bus(1, C0, 0);
    repeat (2) @(posedge hclk);
    q.delete();
    repeat (20) @(posedge hclk);
    bus(0, CS, 0);
    chk("busy after halt", 32'h0, 32'(r[0]));
  endtask
  // Every start is compared with the oldest queued channel
  always @(negedge hclk) begin
    if (conv_start === 1'b1) begin
      if (q.size() == 0) chk("stray start", 32'h0, 32'h1);
      else chk("conv_sel", q.pop_front(), 32'(conv_sel));
    end
  end
  // ------------------------------------
  // Sequence
  // ------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
    hsize = 3'h2;
    ext_trigger_in = 1'b1;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    r = $urandom(46);
    // Reset values, an unmapped offset, last result
    for (int i = 0; i < 6; i++) begin
      bus(0, (i < 5) ? 8'(i * 4) : adss_pkg::OFF_RESULT_LAST, 0);
      chk("reset read", 32'h0, r);
      chk("hresp", 32'h0, 32'(hresp));
    end
    // Single sweeps at every width, the last one through mode code 3
    // one group per sweep
    for (int w = 0; w < 4; w++) begin
      slow <= 1'($urandom);
      bus(1, C1, 32'(w));
      bus(1, C2, 32'({gc[w], 1'b0}));
      for (int c = 0; c <= 2 * w + 1; c++) q.push_back(32'({gd[w], 3'(c)}));
      bus(1, C0, (w == 3) ? 32'hB : 32'h8);
      wt(1);
      chk("queue drained", 32'h0, 32'(q.size()));
      bus(0, C0, 0);
      chk("run cleared", (w == 3) ? 32'h3 : 32'h0, r);
      for (int c = 0; c < 8; c++) begin
        bus(0, 8'(adss_pkg::OFF_RESULT_BASE + 4 * c), 0);
        chk("result", (c <= 2 * w + 1) ? dat(gd[w], 3'(c)) : 32'h0, r);
      end
    end
    // Repeat sweep 0 over two channels of the third group
    bus(1, C1, 0);
    bus(1, C2, 32'h6);
    for (int i = 0; i < 12; i++) q.push_back(32'({2'h2, 3'(i % 2)}));
    rep(32'h9);
    // Repeat sweep 1 with two primaries
    bus(1, C1, 32'h1);
    bus(1, C2, 0);
    for (int k = 2; k < 8; k++) begin
      q.push_back(0);
      q.push_back(1);
      q.push_back(k);
    end
    rep(32'hA);
    // Trigger edge before arming is ignored, the one after starts
    bus(1, C1, 0);
    ext_trigger_in <= 1'b0;
    @(posedge hclk);
    ext_trigger_in <= 1'b1;
    bus(1, C0, 32'hC);
    repeat (10) @(posedge hclk);
    bus(0, CS, 0);
    chk("armed", 32'h1, 32'(r[1]));
    q.push_back(0);
    q.push_back(1);
    ext_trigger_in <= 1'b0;
    wt(1);
    chk("trigger sweep", 32'h0, 32'(q.size()));
    bus(0, C0, 0);
    chk("run kept", 32'hC, r);
    ext_trigger_in <= 1'b1;
    bus(1, C0, 0);
    print_verdict();
  end
endmodule
